/* File: design/sidcc_defs.svh */
// register offsets, field positions, reset values and sizes of the serial data and checksum block
`ifndef SIDCC_DEFS_SVH
`define SIDCC_DEFS_SVH
`define SIDCC_OFF_CTRL      8'h00
`define SIDCC_OFF_STAT      8'h04
`define SIDCC_OFF_DATA      8'h0C
`define SIDCC_OFF_POLY      8'h10
`define SIDCC_OFF_RECEIVE_CHECKSUM      8'h14
`define SIDCC_OFF_TRANSMIT_CHECKSUM      8'h18
`define SIDCC_OFF_ACTL      8'h1C
`define SIDCC_OFF_ADIV      8'h20
`define SIDCC_OFF_QCTL      8'h80
`define SIDCC_RST_POLY      16'h0007
`define SIDCC_RST_DIV       8'h02
`define SIDCC_CTRL_CHECKSUM_ENABLE    0
`define SIDCC_CTRL_LSBF     1
`define SIDCC_CTRL_BYTE_ACCESS_SELECT    2
`define SIDCC_CTRL_FRM16    3
`define SIDCC_CTRL_CRCL16   4
`define SIDCC_CTRL_SPIEN    5
`define SIDCC_STAT_RXNE     0
`define SIDCC_STAT_TXE      1
`define SIDCC_STAT_TRANSFER_ACTIVE    7
`define SIDCC_STAT_IO2      8
`define SIDCC_STAT_IO3      9
`define SIDCC_ACTL_SEL      11
`define SIDCC_ACTL_EN       10
`define SIDCC_ACTL_ROLE     8
`define SIDCC_ACTL_PCMS     7
`define SIDCC_ACTL_STD      4
`define SIDCC_ACTL_IDLE_CLOCK_LEVEL     3
`define SIDCC_ACTL_WIDTH    1
`define SIDCC_ACTL_SLOT     0
`define SIDCC_ADIV_MCKOE    9
`define SIDCC_ADIV_ODD      8
`define SIDCC_ADIV_DIV      0
`define SIDCC_QCTL_DRV      2
`define SIDCC_QCTL_QRD      1
`define SIDCC_QCTL_FOUR_LINE_ENABLE     0
`define SIDCC_FIFO_DEPTH    3'h4
`define SIDCC_BUF_DEPTH     3'h1
`endif

/* File: design/sidcc_pkg.sv */
// types shared by the serial data and checksum block
package sidcc_pkg;

  typedef enum logic [1:0] {
    SIDCC_ROLE_SLV_TX = 2'h0,
    SIDCC_ROLE_SLV_RX = 2'h1,
    SIDCC_ROLE_MST_TX = 2'h2,
    SIDCC_ROLE_MST_RX = 2'h3
  } sidcc_role_t;

  typedef enum logic [1:0] {
    SIDCC_STD_I2S  = 2'h0,
    SIDCC_STD_MSBJ = 2'h1,
    SIDCC_STD_LSBJ = 2'h2,
    SIDCC_STD_PCM  = 2'h3
  } sidcc_std_t;

  typedef enum logic [1:0] {
    SIDCC_W16  = 2'h0,
    SIDCC_W24  = 2'h1,
    SIDCC_W32  = 2'h2,
    SIDCC_WRSV = 2'h3
  } sidcc_width_t;

  // gray order along idle -> shift -> done
  typedef enum logic [1:0] {
    SIDCC_IDLE  = 2'h0,
    SIDCC_SHIFT = 2'h1,
    SIDCC_DONE  = 2'h3
  } sidcc_state_t;

  typedef struct packed {
    logic [1:0]        sclkSync;
    logic [1:0]        csSync;
    logic [1:0]        mosiSync;
    logic [1:0]        io2Sync;
    logic [1:0]        io3Sync;
    logic              sclkPrev;
    logic              ack;
    logic [31:0]       rdata;
    logic              checksum_enable;
    logic              lsbFirst;
    logic              byteAcc;
    logic              frame16;
    logic              crcLen16;
    logic              spiEn;
    logic [15:0]       poly;
    logic [15:0]       rxCrc;
    logic [15:0]       txCrc;
    logic              audSel;
    logic              audEn;
    sidcc_role_t       role;
    logic              pcmLong;
    sidcc_std_t        std;
    logic              idleHigh;
    sidcc_width_t      width;
    logic              slot32;
    logic              mckOe;
    logic              oddDiv;
    logic [7:0]        divFactor;
    logic              ioDrive;
    logic              quadRead;
    logic              fourLine;
    logic [3:0][15:0]  txMem;
    logic [3:0][15:0]  rxMem;
    logic [1:0]        txRd;
    logic [1:0]        txWr;
    logic [1:0]        rxRd;
    logic [1:0]        rxWr;
    logic [2:0]        txCnt;
    logic [2:0]        rxCnt;
    sidcc_state_t      st;
    logic [15:0]       txSh;
    logic [15:0]       rxSh;
    logic [4:0]        bitCnt;
    logic              misoOut;
    logic [8:0]        divCnt;
    logic              mclk;
    logic              bclk;
  } sidcc_regs_t;

endpackage

/* File: design/sidcc_top.sv */
// serial data port, checksum, audio configuration and quad-line control block
//
// Functional notes
// - fifo instance: write pushes, read pops
// - buffer instance: write loads, read returns buffer
// - buffer 8-bit frames: upper byte reads zero
// - buffer 16-bit frames: full halfword transferred
// - fifo access width follows byte-access bit only
// - polynomial register feeds checksum, resets to 7
// - receive checksum, CRC8 or CRC16 by frame
// - fifo: CRC8 only for 8-bit length and size
// - receive checksum updated every received bit
// - transmit checksum, same width selection as receive
// - transmit checksum per bit, depends on order
// - checksums clear on enable set or reset
// - mode bit selects SPI or audio, audio enable
// - audio role field decodes four roles
// - audio standard field decodes four standards
// - pcm sync length short or long
// - idle level sets idle bit clock level
// - sample width 16/24/32, 11 reserved
// - slot width 16 or 32 bits
// - audio divider is twice factor plus odd
// - master clock output gated by enable bit
// - quad enable and read select bits, writable on the fifo instance only
// - single-line mode drives upper lines high when the drive bit is set, fifo instance only
// - transfer-active flag shows frame in progress
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "sidcc_defs.svh"

module sidcc_top
  import sidcc_pkg::*;
#(
  parameter bit USE_FIFO = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        perRst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        spiSclk,
  input  wire logic        spiCsN,
  input  wire logic        spiMosi,
  output logic             spiMiso,
  input  wire logic        io2In,
  output logic             io2Out,
  output logic             io2OeN,
  input  wire logic        io3In,
  output logic             io3Out,
  output logic             io3OeN,
  output logic             audioMasterClock,
  output logic             audioBitClock,
  output logic             audioBitClockOeN,
  output logic             transferActive,
  output logic             fourLineMode,
  output logic             quadReadDir
);

  localparam logic [2:0] DEPTH = USE_FIFO ? `SIDCC_FIFO_DEPTH : `SIDCC_BUF_DEPTH;

  sidcc_regs_t q_r;
  sidcc_regs_t q_nxt;
  logic [1:0]  rstSync_r;
  logic        rstN;

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // one serial step of the checksum; the 8-bit form keeps the upper byte clear
  function automatic logic [15:0] crcStep(input logic [15:0] crc, input logic b,
                                          input logic [15:0] poly, input logic is8);
    logic        fb;
    logic [15:0] nx;
    fb = b ^ (is8 ? crc[7] : crc[15]);
    nx = {crc[14:0], 1'b0} ^ (fb ? poly : 16'h0000);
    if (is8) begin
      nx = {8'h00, nx[7:0]};
    end
    return nx;
  endfunction

  // bit currently presented on the data line for the chosen order and frame
  function automatic logic outBit(input logic [15:0] sh, input logic lsb, input logic f16);
    return lsb ? sh[0] : (f16 ? sh[15] : sh[7]);
  endfunction

  // state image after any reset; shared by the async and the peripheral reset
  function automatic sidcc_regs_t resetImage();
    sidcc_regs_t r;
    r           = '0;
    r.poly      = `SIDCC_RST_POLY;
    r.divFactor = `SIDCC_RST_DIV;
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // reset release

  // async assert, released through two flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstSync_r <= 2'h0;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end
  assign rstN = rstSync_r[1];

  //////////////////////////////////////////////////////////////////////////////
  // next-state logic

  logic        req;
  logic        accept;
  logic        wrAcc;
  logic        rdAcc;
  logic        sclkRise;
  logic        sclkFall;
  logic        linkActive;
  logic        pushTx;
  logic        popTx;
  logic        pushRx;
  logic        popRx;
  logic        is8;
  logic        narrow;
  logic        b;
  logic [4:0]  frameLen;
  logic [8:0]  divN;
  logic [8:0]  divInc;
  logic [31:0] rdMux;
  logic [15:0] rxHead;
  logic [15:0] wdat;

  always_comb begin
    q_nxt      = q_r;
    pushTx     = 1'b0;
    popTx      = 1'b0;
    pushRx     = 1'b0;
    popRx      = 1'b0;
    rdMux      = 32'h0000_0000;
    b          = q_r.mosiSync[1];
    wdat       = avs_writedata[15:0];

    // pin inputs pass two flops; only the second stage is read below
    q_nxt.sclkSync = {q_r.sclkSync[0], spiSclk};
    q_nxt.csSync   = {q_r.csSync[0], spiCsN};
    q_nxt.mosiSync = {q_r.mosiSync[0], spiMosi};
    q_nxt.io2Sync  = {q_r.io2Sync[0], io2In};
    q_nxt.io3Sync  = {q_r.io3Sync[0], io3In};
    q_nxt.sclkPrev = q_r.sclkSync[1];
    sclkRise       = q_r.sclkSync[1] & ~q_r.sclkPrev;
    sclkFall       = ~q_r.sclkSync[1] & q_r.sclkPrev;

    // one wait state: request seen, data prepared, taken on the next edge
    req       = avs_read | avs_write;
    q_nxt.ack = req & ~q_r.ack;
    accept    = req & q_r.ack;
    wrAcc     = accept & avs_write;
    rdAcc     = accept & avs_read;

    // narrow data: fifo by byte-access bit alone, buffer by frame format
    narrow = USE_FIFO ? q_r.byteAcc : ~q_r.frame16;
    rxHead = q_r.rxMem[q_r.rxRd];
    if (narrow) begin
      rxHead = {8'h00, rxHead[7:0]};
    end
    // fifo: CRC8 only when both length and size are 8 bits
    is8      = USE_FIFO ? (~q_r.crcLen16 & ~q_r.frame16) : ~q_r.frame16;
    frameLen = q_r.frame16 ? 5'h10 : 5'h08;

    // register read mux, latched in the wait cycle
    case (avs_address)
      `SIDCC_OFF_CTRL: begin
        rdMux[`SIDCC_CTRL_CHECKSUM_ENABLE]  = q_r.checksum_enable;
        rdMux[`SIDCC_CTRL_LSBF]   = q_r.lsbFirst;
        rdMux[`SIDCC_CTRL_BYTE_ACCESS_SELECT]  = q_r.byteAcc;
        rdMux[`SIDCC_CTRL_FRM16]  = q_r.frame16;
        rdMux[`SIDCC_CTRL_CRCL16] = q_r.crcLen16;
        rdMux[`SIDCC_CTRL_SPIEN]  = q_r.spiEn;
      end
      `SIDCC_OFF_STAT: begin
        rdMux[`SIDCC_STAT_RXNE]  = q_r.rxCnt != 3'h0;
        rdMux[`SIDCC_STAT_TXE]   = q_r.txCnt == 3'h0;
        rdMux[`SIDCC_STAT_TRANSFER_ACTIVE] = q_r.st != SIDCC_IDLE;
        rdMux[`SIDCC_STAT_IO2]   = q_r.io2Sync[1];
        rdMux[`SIDCC_STAT_IO3]   = q_r.io3Sync[1];
      end
      `SIDCC_OFF_DATA: rdMux[15:0] = rxHead;
      `SIDCC_OFF_POLY: rdMux[15:0] = q_r.poly;
      `SIDCC_OFF_RECEIVE_CHECKSUM: rdMux[15:0] = q_r.rxCrc;
      `SIDCC_OFF_TRANSMIT_CHECKSUM: rdMux[15:0] = q_r.txCrc;
      `SIDCC_OFF_ACTL: begin
        rdMux[`SIDCC_ACTL_SEL]                        = q_r.audSel;
        rdMux[`SIDCC_ACTL_EN]                         = q_r.audEn;
        rdMux[`SIDCC_ACTL_ROLE+1:`SIDCC_ACTL_ROLE]    = q_r.role;
        rdMux[`SIDCC_ACTL_PCMS]                       = q_r.pcmLong;
        rdMux[`SIDCC_ACTL_STD+1:`SIDCC_ACTL_STD]      = q_r.std;
        rdMux[`SIDCC_ACTL_IDLE_CLOCK_LEVEL]                       = q_r.idleHigh;
        rdMux[`SIDCC_ACTL_WIDTH+1:`SIDCC_ACTL_WIDTH]  = q_r.width;
        rdMux[`SIDCC_ACTL_SLOT]                       = q_r.slot32;
      end
      `SIDCC_OFF_ADIV: begin
        rdMux[`SIDCC_ADIV_MCKOE]                      = q_r.mckOe;
        rdMux[`SIDCC_ADIV_ODD]                        = q_r.oddDiv;
        rdMux[`SIDCC_ADIV_DIV+7:`SIDCC_ADIV_DIV]      = q_r.divFactor;
      end
      `SIDCC_OFF_QCTL: begin
        rdMux[`SIDCC_QCTL_DRV]  = q_r.ioDrive;
        rdMux[`SIDCC_QCTL_QRD]  = q_r.quadRead;
        rdMux[`SIDCC_QCTL_FOUR_LINE_ENABLE] = q_r.fourLine;
      end
      default: rdMux = 32'h0000_0000;
    endcase
    if (q_nxt.ack && avs_read) begin
      q_nxt.rdata = rdMux;
    end

    // data port pops and pushes take effect at the accepting edge
    if (avs_address == `SIDCC_OFF_DATA) begin
      popRx  = rdAcc & (q_r.rxCnt != 3'h0);
      pushTx = wrAcc & (q_r.txCnt < DEPTH);
    end

    // register writes; byte lanes honoured outside the data port
    if (wrAcc) begin
      case (avs_address)
        `SIDCC_OFF_CTRL: if (avs_byteenable[0]) begin
          q_nxt.checksum_enable    = avs_writedata[`SIDCC_CTRL_CHECKSUM_ENABLE];
          q_nxt.lsbFirst = avs_writedata[`SIDCC_CTRL_LSBF];
          q_nxt.byteAcc  = avs_writedata[`SIDCC_CTRL_BYTE_ACCESS_SELECT];
          q_nxt.frame16  = avs_writedata[`SIDCC_CTRL_FRM16];
          q_nxt.crcLen16 = avs_writedata[`SIDCC_CTRL_CRCL16];
          q_nxt.spiEn    = avs_writedata[`SIDCC_CTRL_SPIEN];
        end
        `SIDCC_OFF_POLY: begin
          if (avs_byteenable[0]) q_nxt.poly[7:0] = avs_writedata[7:0];
          if (avs_byteenable[1]) q_nxt.poly[15:8] = avs_writedata[15:8];
        end
        `SIDCC_OFF_ACTL: begin
          if (avs_byteenable[0]) begin
            q_nxt.pcmLong  = avs_writedata[`SIDCC_ACTL_PCMS];
            q_nxt.std      = sidcc_std_t'(avs_writedata[`SIDCC_ACTL_STD+1:`SIDCC_ACTL_STD]);
            q_nxt.idleHigh = avs_writedata[`SIDCC_ACTL_IDLE_CLOCK_LEVEL];
            q_nxt.width    = sidcc_width_t'(avs_writedata[`SIDCC_ACTL_WIDTH+1:`SIDCC_ACTL_WIDTH]);
            q_nxt.slot32   = avs_writedata[`SIDCC_ACTL_SLOT];
          end
          if (avs_byteenable[1]) begin
            q_nxt.audSel = avs_writedata[`SIDCC_ACTL_SEL];
            q_nxt.audEn  = avs_writedata[`SIDCC_ACTL_EN];
            q_nxt.role   = sidcc_role_t'(avs_writedata[`SIDCC_ACTL_ROLE+1:`SIDCC_ACTL_ROLE]);
          end
        end
        `SIDCC_OFF_ADIV: begin
          if (avs_byteenable[0]) q_nxt.divFactor = avs_writedata[7:0];
          if (avs_byteenable[1]) begin
            q_nxt.oddDiv = avs_writedata[`SIDCC_ADIV_ODD];
            q_nxt.mckOe  = avs_writedata[`SIDCC_ADIV_MCKOE];
          end
        end
        `SIDCC_OFF_QCTL: if (avs_byteenable[0] && USE_FIFO) begin
          q_nxt.ioDrive  = avs_writedata[`SIDCC_QCTL_DRV];
          q_nxt.quadRead = avs_writedata[`SIDCC_QCTL_QRD];
          q_nxt.fourLine = avs_writedata[`SIDCC_QCTL_FOUR_LINE_ENABLE];
        end
        default: ;
      endcase
    end

    // serial engine: link clock sampled, rising edge captures, falling edge shifts
    linkActive = q_r.spiEn & ~q_r.audSel & ~q_r.csSync[1];
    case (q_r.st)
      SIDCC_IDLE: if (linkActive) begin
        q_nxt.st     = SIDCC_SHIFT;
        q_nxt.bitCnt = 5'h00;
        q_nxt.rxSh   = 16'h0000;
        q_nxt.txSh   = (q_r.txCnt != 3'h0) ? q_r.txMem[q_r.txRd] : 16'h0000;  // peek only; underrun sends zeros
      end
      SIDCC_SHIFT: begin
        if (!linkActive) begin
          q_nxt.st = SIDCC_IDLE;                                          // frame aborted by select
        end else if (sclkRise) begin
          // word leaves the queue only once clocked, so a frame cut before its first edge keeps it
          popTx = (q_r.bitCnt == 5'h00) & (q_r.txCnt != 3'h0);
          if (q_r.lsbFirst) begin
            q_nxt.rxSh = q_r.frame16 ? {b, q_r.rxSh[15:1]} : {8'h00, b, q_r.rxSh[7:1]};
          end else begin
            q_nxt.rxSh = {q_r.rxSh[14:0], b};
          end
          if (q_r.checksum_enable) begin
            q_nxt.rxCrc = crcStep(q_r.rxCrc, b, q_r.poly, is8);
            q_nxt.txCrc = crcStep(q_r.txCrc, outBit(q_r.txSh, q_r.lsbFirst, q_r.frame16),
                                  q_r.poly, is8);
          end
          q_nxt.bitCnt = 5'(q_r.bitCnt + 5'h01);
          if (q_nxt.bitCnt == frameLen) begin
            q_nxt.st = SIDCC_DONE;
          end
        end else if (sclkFall) begin
          q_nxt.txSh = q_r.lsbFirst ? {1'b0, q_r.txSh[15:1]} : {q_r.txSh[14:0], 1'b0};
        end else if (q_r.bitCnt == 5'h00) begin
          q_nxt.txSh = (q_r.txCnt != 3'h0) ? q_r.txMem[q_r.txRd] : 16'h0000;  // follow the head until the first edge
        end
      end
      SIDCC_DONE: begin
        pushRx   = q_r.rxCnt < DEPTH;                                     // full: frame dropped
        q_nxt.st = SIDCC_IDLE;
      end
      default: q_nxt.st = SIDCC_IDLE;
    endcase
    q_nxt.misoOut = outBit(q_nxt.txSh, q_r.lsbFirst, q_r.frame16);

    // queue bookkeeping; one entry deep on the buffer instance
    if (pushTx) begin
      q_nxt.txMem[q_r.txWr] = narrow ? {8'h00, wdat[7:0]} : wdat;
      q_nxt.txWr            = 2'(q_r.txWr + 2'h1);
    end
    if (popTx) q_nxt.txRd = 2'(q_r.txRd + 2'h1);
    if (pushRx) begin
      q_nxt.rxMem[q_r.rxWr] = q_r.frame16 ? q_r.rxSh : {8'h00, q_r.rxSh[7:0]};
      q_nxt.rxWr            = 2'(q_r.rxWr + 2'h1);
    end
    if (popRx) q_nxt.rxRd = 2'(q_r.rxRd + 2'h1);
    q_nxt.txCnt = 3'(q_r.txCnt + {2'h0, pushTx} - {2'h0, popTx});
    q_nxt.rxCnt = 3'(q_r.rxCnt + {2'h0, pushRx} - {2'h0, popRx});

    // audio divider: period of 2*factor+odd cycles, high for the first half
    divN   = {q_r.divFactor, 1'b0} + {8'h00, q_r.oddDiv};
    divInc = 9'(q_r.divCnt + 9'h001);
    if (q_r.audSel && q_r.audEn && divN > 9'h001) begin
      q_nxt.divCnt = (divInc >= divN) ? 9'h000 : divInc;
      q_nxt.mclk   = q_nxt.divCnt < {1'b0, divN[8:1]};
    end else begin
      q_nxt.divCnt = 9'h000;
      q_nxt.mclk   = 1'b0;
    end
    // bit clock rests at the idle level; simplified to follow the divided clock
    q_nxt.bclk = q_r.idleHigh ^ (q_nxt.mclk & q_r.role[1]);

    // a set enable bit or the peripheral reset clears both checksums
    if (wrAcc && avs_address == `SIDCC_OFF_CTRL && avs_byteenable[0] &&
        avs_writedata[`SIDCC_CTRL_CHECKSUM_ENABLE]) begin
      q_nxt.rxCrc = 16'h0000;
      q_nxt.txCrc = 16'h0000;
    end
    if (perRst) begin
      q_nxt = resetImage();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      q_r <= resetImage();
    end else begin
      q_r <= q_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign avs_waitrequest  = req & ~q_r.ack;
  assign avs_readdata     = q_r.rdata;
  assign spiMiso          = q_r.misoOut;
  assign transferActive   = q_r.st != SIDCC_IDLE;
  assign fourLineMode     = q_r.fourLine;
  assign quadReadDir      = q_r.quadRead;
  // upper lines held high only in single-line mode with drive set
  assign io2Out           = 1'b1;
  assign io3Out           = 1'b1;
  assign io2OeN           = ~(q_r.ioDrive & ~q_r.fourLine);
  assign io3OeN           = ~(q_r.ioDrive & ~q_r.fourLine);
  // master clock pin off in SPI mode whatever the enable says
  assign audioMasterClock = q_r.mclk & q_r.mckOe & q_r.audSel;
  assign audioBitClock    = q_r.audSel ? q_r.bclk : 1'b0;
  assign audioBitClockOeN = ~(q_r.audSel & q_r.role[1]);

endmodule
`default_nettype wire

/* File: tb/sidcc_checker.sv */
// concurrent checks on the bus, link and quad pins
`timescale 1ns/1ps
`default_nettype none
module sidcc_checker (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        perRst,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        spiCsN,
  input wire logic        io2Out,
  input wire logic        io2OeN,
  input wire logic        io3Out,
  input wire logic        io3OeN,
  input wire logic        transferActive,
  input wire logic        fourLineMode,
  input wire logic        quadReadDir
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////
  // accepted access, quad write, chip select quiet long enough to end a frame
  sequence s_take; (avs_read || avs_write) && !avs_waitrequest; endsequence
  sequence s_qwr; avs_write && !avs_waitrequest && avs_address == 8'h80; endsequence
  sequence s_csIdle; spiCsN [*5]; endsequence
  property p_oneWait; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  property p_dataHi; s_take ##0 (avs_read && avs_address == 8'h0C) |-> avs_readdata[31:16] == 16'h0000; endproperty
  property p_actStart; $rose(transferActive) |-> $past(spiCsN, 2) == 1'b0; endproperty
  property p_actStop; s_csIdle |-> !transferActive; endproperty
  property p_four_line_enable; s_qwr |=> fourLineMode == $past(avs_writedata[0]); endproperty
  property p_qrd; s_qwr |=> quadReadDir == $past(avs_writedata[1]); endproperty
  // quad mode must never move without a write or a peripheral reset
  property p_qHold; $changed(fourLineMode) |-> $past(perRst) || $past(avs_write && avs_address == 8'h80); endproperty
  property p_drv; !io2OeN |-> io2Out && io3Out && !io3OeN && !fourLineMode; endproperty
  a_oneWait: assert property (p_oneWait) else $error("access waited over one cycle");
  a_dataHi: assert property (p_dataHi) else $error("data port upper half not zero");
  a_actStart: assert property (p_actStart) else $error("frame began without select");
  a_actStop: assert property (p_actStop) else $error("active flag stuck after deselect");
  a_four_line_enable: assert property (p_four_line_enable) else $error("four-line flag differs from write");
  a_qrd: assert property (p_qrd) else $error("read direction differs from write");
  a_qHold: assert property (p_qHold) else $error("four-line flag moved on its own");
  a_drv: assert property (p_drv) else $error("upper lines driven but not high");
endmodule
bind sidcc_top sidcc_checker chk_u (.clk(clk), .arst_n(arst_n), .perRst(perRst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .spiCsN(spiCsN), .io2Out(io2Out), .io2OeN(io2OeN), .io3Out(io3Out),
  .io3OeN(io3OeN), .transferActive(transferActive), .fourLineMode(fourLineMode), .quadReadDir(quadReadDir));
`default_nettype wire

/* File: tb/sidcc_spi_host.sv */
// external mode-0 SPI master on the link pins
`timescale 1ns/1ps
`default_nettype none
module sidcc_spi_host (
  input  wire logic clk,
  output logic      sclk,
  output logic      csN,
  output logic      mosi,
  input  wire logic miso
);
  ////////////////////////////////////////
  // clock stands low and select high between frames
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    mosi = 1'b0;
  end
  // one frame, 800 ns link period, miso taken at each rising link edge
  task automatic xfer(input logic [15:0] tx, input int n, input bit lsb, output logic [15:0] rx);
    int i;
    int b;
    rx = 16'h0000;
    csN <= 1'b0;
    repeat (4) @(posedge clk);
    for (i = 0; i < n; i++) begin
      b = lsb ? i : n - 1 - i;
      mosi <= tx[b];
      repeat (4) @(posedge clk);
      rx[b] = miso;
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    csN <= 1'b1;
    mosi <= ~mosi; // released line must not keep the last bit
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// bench: registers, link frames and quad pins against a queue model
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk, arst_n, perRst, avsRead, avsWrite, sclk, csN, mosi, miso, avsWait, f16;
  logic        io2Out, io2OeN, io3Out, io3OeN, mclk, bclk, bclkOeN, active, quad, quad_read_select, q;
  logic [7:0]  avsAddr;
  logic [3:0]  be;
  logic [31:0] avsWdata, avsRdata, s, w, p, v;
  logic [15:0] got, m, rc, tc, t;
  logic [15:0] txq[$], rxq[$];
  int          miscompares, n_compared, i, b, k, n;
  logic [39:0] rstTab[7] = '{40'h1000000007, 40'h2000000002, 40'h1400000000, 40'h1800000000,
                             40'h1C00000000, 40'h8000000000, 40'h4000000000};
  sidcc_top #(.USE_FIFO(1'b1)) dut_u (.clk(clk), .arst_n(arst_n), .perRst(perRst), .avs_address(avsAddr),
    .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWdata), .avs_byteenable(be),
    .avs_readdata(avsRdata), .avs_waitrequest(avsWait), .spiSclk(sclk), .spiCsN(csN), .spiMosi(mosi),
    .spiMiso(miso), .io2In(io2OeN ? 1'b0 : io2Out), .io2Out(io2Out), .io2OeN(io2OeN),
    .io3In(io3OeN ? 1'b0 : io3Out), .io3Out(io3Out), .io3OeN(io3OeN), .audioMasterClock(mclk),
    .audioBitClock(bclk), .audioBitClockOeN(bclkOeN), .transferActive(active), .fourLineMode(quad),
    .quadReadDir(quad_read_select));
  sidcc_spi_host host_u (.clk(clk), .sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso));
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // serial checksum step, width picked by the frame size under test
  function automatic logic [15:0] step(input logic [15:0] c, input logic d);
    logic fb;
    fb = d ^ (f16 ? c[15] : c[7]);
    c = (c << 1) ^ (fb ? p[15:0] : 16'h0000);
    return f16 ? c : {8'h00, c[7:0]};
  endfunction
  task automatic end_sim();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] sv, input logic [31:0] ev);
    n_compared++;
    if (sv !== ev) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, sv, ev);
    end
  endtask
  // one access held until waitrequest is seen low; a hung slave ends the run
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int c;
    avsAddr <= a;
    avsWdata <= d;
    avsWrite <= wr;
    avsRead <= ~wr;
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (avsWait !== 1'b0 && c < 40);
    r = avsRdata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    if (avsWait !== 1'b0) begin
      miscompares++;
      end_sim();
    end
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  // edges between two sampled rises of the master clock
  task automatic riseGap();
    n = 0;
    do begin
      q = mclk;
      @(posedge clk);
      n++;
    end while (!(q === 1'b0 && mclk === 1'b1) && n < 60);
  endtask
  ////////////////////////////////////////
  initial begin
    s = 32'h000059E0;
    {arst_n, perRst, avsRead, avsWrite, avsAddr, avsWdata} = '0;
    be = 4'hF;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (rstTab[x]) rd(rstTab[x][39:32], rstTab[x][31:0]);
    // every role and standard; 32-bit slot keeps any legal width, reserved width avoided
    for (i = 0; i < 4; i++) begin
      v = rnd();
      v = {20'h0, 2'b11, i[1:0], v[7], 1'b0, i[1:0], v[3], (i == 3) ? 2'h0 : i[1:0], 1'b1};
      wr(8'h1C, v);
      rd(8'h1C, v);
    end
    wr(8'h20, 32'h00000303);
    riseGap();
    riseGap();
    chk(n, 7);
    wr(8'h20, 32'h00000103);
    n = 0;
    repeat (20) begin
      @(posedge clk);
      if (mclk !== 1'b0) n++;
    end
    chk(n, 0);
    chk(bclkOeN, 0);
    wr(8'h1C, 32'h00000808);
    @(posedge clk);
    chk({bclk, bclkOeN}, 2'h3);
    wr(8'h1C, 32'h0);
    // quad control only while the link is idle
    wr(8'h80, 32'h4);
    chk({io2OeN, io3OeN, io2Out, io3Out, quad}, 5'h06);
    repeat (2) @(posedge clk);
    rd(8'h04, 32'h302);
    wr(8'h80, 32'h3);
    chk({quad, quad_read_select, io2OeN}, 3'h7);
    wr(8'h80, 32'h0);
    // 8-bit CRC8 and 16-bit CRC16 frames, both bit orders, two queued words each
    for (k = 0; k < 4; k++) begin
      f16 = k[1];
      n = f16 ? 16 : 8;
      m = f16 ? 16'hFFFF : 16'h00FF;
      p = rnd() | 32'h1;
      wr(8'h10, {16'h0, p[15:0]});
      wr(8'h00, {26'h0, 1'b1, f16, f16, ~f16, k[0], 1'b1});
      rc = '0;
      tc = '0;
      repeat (2) begin
        w = rnd();
        be <= w[19:16];
        wr(8'h0C, w);
        txq.push_back(w[15:0] & m);
      end
      be <= 4'hF;
      repeat (2) begin
        w = rnd();
        t = txq.pop_front();
        host_u.xfer(w[15:0], n, k[0], got);
        chk(got, t);
        for (i = 0; i < n; i++) begin
          b = k[0] ? i : n - 1 - i;
          rc = step(rc, w[b]);
          tc = step(tc, t[b]);
        end
        rxq.push_back(w[15:0] & m);
      end
      rd(8'h14, rc);
      rd(8'h18, tc);
      repeat (2) rd(8'h0C, rxq.pop_front());
    end
    wr(8'h10, 32'h00001234);
    perRst <= 1'b1;
    @(posedge clk);
    perRst <= 1'b0;
    @(posedge clk);
    rd(8'h10, 32'h7);
    rd(8'h14, 32'h0);
    rd(8'h18, 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
